// ==== include/ustm_defines.vh ====
// Constants shared by the serial transmitter with Manchester encoder
// What this block does
// - Start, up to nine data, parity, stop bits
// - Nine-bit select overrides the length field
// - Parity: even, odd, space, mark or none
// - Bit order select picks MSB or LSB first
// - Stop count; one-and-half only when asynchronous
// - Finished character pulls next, holding becomes free
// - All-done only when every character fully sent
// - Disabled transmitter shows both flags low
// - Write while not free is dropped
// - Manchester enable sends biphase cells, mid transition
// - Default polarity: zero low-high, one high-low
// - Preamble of 1 to 15 bits; zero none
// - Preamble pattern: ones, zeros, one-zero, zero-one
// - Single-bit delimiter is a Manchester zero
// - Otherwise three-bit sync, transition mid second bit
// - Command sync: high 1.5 bits, low 1.5
// - Sync type select picks command or data sync
// - Variable sync takes type from written bit
// - Drift compensation only 16x and when enabled
// - Edge within one sample clock is jitter
// - Edge 4 to 2 early shortens period
// - Edge 2 to 3 late lengthens period
// - Out of reset disabled until enable command
`ifndef USTM_DEFINES_VH
`define USTM_DEFINES_VH

// Parity select codes
`define USTM_PAR_EVEN 3'h0
`define USTM_PAR_ODD 3'h1
`define USTM_PAR_SPACE 3'h2
`define USTM_PAR_MARK 3'h3

// Stop bit count codes
`define USTM_STOP_1 2'h0
`define USTM_STOP_1P5 2'h1
`define USTM_STOP_2 2'h2

// Preamble pattern codes
`define USTM_PP_ALL_ONE 2'h0
`define USTM_PP_ALL_ZERO 2'h1
`define USTM_PP_ONE_ZERO 2'h2
`define USTM_PP_ZERO_ONE 2'h3

// Character layout in the buffer
`define USTM_ENTRY_W 10
`define USTM_SYNC_BIT 9

// Sync pattern length in half bits
`define USTM_SYNC_HALVES 5'h06
`define USTM_SYNC_SWITCH 5'h03

// Drift compensation, in oversampling clocks
`define USTM_OS_NOMINAL 5'h10
`define USTM_OS_SHORT 5'h0F
`define USTM_OS_LONG 5'h11
`define USTM_OS_EIGHT 5'h08
`define USTM_EARLY_FAR 5'h04
`define USTM_EARLY_NEAR 5'h02
`define USTM_LATE_NEAR 5'h02
`define USTM_LATE_FAR 5'h03

`endif

// ==== rtl/ustm_buf.v ====
// Two-entry buffer holding characters waiting for the shifter
`timescale 1ns/10ps
`default_nettype none
module ustm_buf #(
	parameter WIDTH = 10,
	parameter DEPTH = 2
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire rst_n_i,
	// Filling side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	// Draining side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	localparam PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam [PW:0] FULL_CNT = DEPTH[PW:0];
	localparam integer LAST_IDX = DEPTH - 1;
	localparam [PW-1:0] LAST_PTR = LAST_IDX[PW-1:0];

	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [PW-1:0] wr_ptr_r;
	reg [PW-1:0] rd_ptr_r;
	reg [PW:0] cnt_r;
	wire push;
	wire pop;

	assign in_ready_o = (cnt_r != FULL_CNT);
	assign out_valid_o = (cnt_r != {(PW+1){1'b0}});
	assign out_data_o = mem_r[rd_ptr_r];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : gen_entry
			always @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					mem_r[g] <= {WIDTH{1'b0}};
				end else if (push && (wr_ptr_r == g)) begin
					mem_r[g] <= in_data_i;
				end
			end
		end
	endgenerate

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= {PW{1'b0}};
			rd_ptr_r <= {PW{1'b0}};
			cnt_r <= {(PW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? {PW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? {PW{1'b0}} : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/ustm_tx.v ====
// Serial transmitter with Manchester encoder and receive drift compensation
`timescale 1ns/10ps
`default_nettype none
`include "ustm_defines.vh"
module ustm_tx (
	// Clock and reset
	input wire sys_clk_i,
	input wire rst_n_i,
	// Commands
	input wire tx_enable_cmd_i,
	input wire tx_disable_cmd_i,
	// Character mode configuration
	input wire [1:0] char_length_field_i,
	input wire nine_bit_i,
	input wire [2:0] parity_select_i,
	input wire bit_order_select_i,
	input wire [1:0] stop_bit_count_i,
	input wire sync_mode_i,
	// Manchester configuration
	input wire manchester_enable_i,
	input wire [3:0] preamble_length_i,
	input wire [1:0] preamble_pattern_sel_i,
	input wire encode_polarity_i,
	input wire single_bit_delimiter_i,
	input wire sync_type_select_i,
	input wire var_sync_i,
	// Holding register write
	input wire tx_holding_wr_i,
	input wire [8:0] tx_holding_data_i,
	input wire char_sync_type_bit_i,
	// Half bit time strobe from the baud generator
	input wire half_bit_tick_i,
	// Status
	output reg tx_holding_free_o,
	output reg tx_all_done_o,
	output reg tx_enabled_o,
	// Serial line
	output reg txd_o,
	// Drift compensation
	input wire drift_enable_i,
	input wire over8_i,
	input wire os_tick_i,
	input wire rx_line_i,
	output reg rx_bit_tick_o,
	output reg [4:0] rx_period_o
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_PRE = 3'h1;
	localparam [2:0] ST_SYNC = 3'h2;
	localparam [2:0] ST_START = 3'h3;
	localparam [2:0] ST_DATA = 3'h4;
	localparam [2:0] ST_PAR = 3'h5;
	localparam [2:0] ST_STOP = 3'h6;

	reg [2:0] st_r;
	reg [2:0] st_nxt;
	reg [4:0] cnt_r;
	reg [4:0] cnt_nxt;
	reg [8:0] shift_r;
	reg [3:0] nbits_r;
	reg par_r;
	reg par_on_r;
	reg cmd_sync_r;
	reg man_r;
	reg en_r;
	reg dis_pend_r;
	reg level;
	reg [4:0] len;
	reg [3:0] bidx;
	reg dbit;
	reg [3:0] nbits_w;
	reg [8:0] masked;
	reg par_w;
	reg tail_r;
	reg tail_nxt;

	wire buf_in_ready;
	wire buf_out_valid;
	wire [`USTM_ENTRY_W-1:0] buf_out_data;
	wire wr_ok;
	wire pop;
	wire in_sync_bit;
	wire last;
	wire full_nxt;

	// Writes only land while the free flag shows room
	assign wr_ok = tx_holding_wr_i & tx_holding_free_o;
	// Buffer full after this edge, so the free flag never lags a fill
	assign full_nxt = (~buf_in_ready | (buf_out_valid & wr_ok)) & ~pop;
	assign in_sync_bit = var_sync_i ? char_sync_type_bit_i : sync_type_select_i;
	assign pop = (st_r == ST_IDLE) & buf_out_valid;

	ustm_buf #(
		.WIDTH(`USTM_ENTRY_W),
		.DEPTH(2)
	) u_buf (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(wr_ok),
		.in_ready_o(buf_in_ready),
		.in_data_i({in_sync_bit, tx_holding_data_i}),
		.out_valid_o(buf_out_valid),
		.out_ready_i(pop),
		.out_data_o(buf_out_data)
	);

	// Character length and parity of the next character
	always @* begin
		nbits_w = nine_bit_i ? 4'h9 : {2'b01, char_length_field_i} + 4'h1;
		case (nbits_w)
			4'h5: masked = {4'h0, buf_out_data[4:0]};
			4'h6: masked = {3'h0, buf_out_data[5:0]};
			4'h7: masked = {2'h0, buf_out_data[6:0]};
			4'h8: masked = {1'h0, buf_out_data[7:0]};
			default: masked = buf_out_data[8:0];
		endcase
		case (parity_select_i)
			`USTM_PAR_EVEN: par_w = ^masked;
			`USTM_PAR_ODD: par_w = ~^masked;
			`USTM_PAR_SPACE: par_w = 1'b0;
			default: par_w = 1'b1;
		endcase
	end

	// Data bit in transmission order
	always @* begin
		bidx = cnt_r[4:1];
		if (bit_order_select_i) begin
			dbit = shift_r[nbits_r - 4'h1 - bidx];
		end else begin
			dbit = shift_r[bidx];
		end
	end

	// Length of each stage in half bit times
	always @* begin
		case (st_r)
			ST_PRE: len = {preamble_length_i, 1'b0};
			ST_SYNC: len = `USTM_SYNC_HALVES;
			ST_START: len = 5'h02;
			ST_DATA: len = {nbits_r, 1'b0};
			ST_PAR: len = 5'h02;
			ST_STOP: begin
				case (stop_bit_count_i)
					`USTM_STOP_1: len = 5'h02;
					`USTM_STOP_1P5: len = sync_mode_i ? 5'h02 : 5'h03;
					default: len = 5'h04;
				endcase
			end
			default: len = 5'h01;
		endcase
	end

	assign last = (cnt_r == len - 5'h01);

	// Line level for the current half bit
	always @* begin
		case (st_r)
			ST_PRE: begin
				case (preamble_pattern_sel_i)
					`USTM_PP_ALL_ONE: level = 1'b1;
					`USTM_PP_ALL_ZERO: level = 1'b0;
					`USTM_PP_ONE_ZERO: level = ~cnt_r[1];
					default: level = cnt_r[1];
				endcase
				level = level ^ encode_polarity_i ^ cnt_r[0];
			end
			ST_SYNC: begin
				// Command sync high then low, data sync the reverse
				if (cmd_sync_r) begin
					level = (cnt_r < `USTM_SYNC_SWITCH);
				end else begin
					level = (cnt_r >= `USTM_SYNC_SWITCH);
				end
			end
			ST_START: level = man_r ? (encode_polarity_i ^ cnt_r[0]) : 1'b0;
			ST_DATA: level = man_r ? (dbit ^ encode_polarity_i ^ cnt_r[0]) : dbit;
			ST_PAR: level = man_r ? (par_r ^ encode_polarity_i ^ cnt_r[0]) : par_r;
			default: level = 1'b1;
		endcase
	end

	// Stage sequencing
	always @* begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		if (st_r == ST_IDLE) begin
			cnt_nxt = 5'h00;
			if (pop) begin
				if (manchester_enable_i && (preamble_length_i != 4'h0)) begin
					st_nxt = ST_PRE;
				end else if (manchester_enable_i && !single_bit_delimiter_i) begin
					st_nxt = ST_SYNC;
				end else begin
					st_nxt = ST_START;
				end
			end
		end else if (half_bit_tick_i) begin
			cnt_nxt = cnt_r + 5'h01;
			if (last) begin
				cnt_nxt = 5'h00;
				case (st_r)
					ST_PRE: st_nxt = (man_r && !single_bit_delimiter_i) ? ST_SYNC : ST_START;
					ST_SYNC: st_nxt = ST_DATA;
					ST_START: st_nxt = ST_DATA;
					ST_DATA: st_nxt = par_on_r ? ST_PAR : ST_STOP;
					ST_PAR: st_nxt = ST_STOP;
					ST_STOP: st_nxt = ST_IDLE;
					default: st_nxt = ST_IDLE;
				endcase
			end
		end
	end

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= ST_IDLE;
			tail_r <= 1'b0;
			cnt_r <= 5'h00;
			shift_r <= 9'h000;
			nbits_r <= 4'h8;
			par_r <= 1'b0;
			par_on_r <= 1'b0;
			cmd_sync_r <= 1'b0;
			man_r <= 1'b0;
			txd_o <= 1'b1;
		end else begin
			st_r <= st_nxt;
			tail_r <= tail_nxt;
			cnt_r <= cnt_nxt;
			if (pop) begin
				// Shift register takes the oldest waiting character
				shift_r <= buf_out_data[8:0];
				nbits_r <= nbits_w;
				par_r <= par_w;
				par_on_r <= ~parity_select_i[2];
				cmd_sync_r <= buf_out_data[`USTM_SYNC_BIT];
				man_r <= manchester_enable_i;
			end
			if (half_bit_tick_i) begin
				txd_o <= (st_r == ST_IDLE) ? 1'b1 : level;
			end
		end
	end

	// Last stop half stays on the line until the next strobe
	always @* begin
		tail_nxt = tail_r;
		if (half_bit_tick_i) begin
			tail_nxt = 1'b0;
		end
		if ((st_r != ST_IDLE) && (st_nxt == ST_IDLE)) begin
			tail_nxt = 1'b1;
		end
	end

	// Enable, deferred disable and status flags
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_r <= 1'b0;
			dis_pend_r <= 1'b0;
			tx_holding_free_o <= 1'b0;
			tx_all_done_o <= 1'b0;
			tx_enabled_o <= 1'b0;
		end else begin
			if (tx_enable_cmd_i) begin
				en_r <= 1'b1;
				dis_pend_r <= 1'b0;
			end else if (tx_disable_cmd_i) begin
				dis_pend_r <= 1'b1;
			end else if (dis_pend_r && (st_r == ST_IDLE) && !buf_out_valid && !wr_ok) begin
				en_r <= 1'b0;
				dis_pend_r <= 1'b0;
			end
			tx_enabled_o <= en_r;
			tx_holding_free_o <= en_r & ~dis_pend_r & ~full_nxt;
			tx_all_done_o <= en_r & (st_nxt == ST_IDLE) & ~tail_nxt & ~buf_out_valid & ~wr_ok;
		end
	end

	// Receive drift compensation on the oversampling clock
	reg rx_prev_r;
	reg [4:0] ph_r;
	reg [4:0] per_r;
	reg adj_done_r;
	wire drift_on;
	wire rx_edge;
	wire [4:0] early;
	wire ph_end;

	assign drift_on = drift_enable_i & ~over8_i;
	assign rx_edge = os_tick_i & (rx_line_i ^ rx_prev_r);
	assign early = per_r - ph_r;
	assign ph_end = (ph_r == per_r - 5'h01);

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_prev_r <= 1'b1;
			ph_r <= 5'h00;
			per_r <= `USTM_OS_NOMINAL;
			adj_done_r <= 1'b0;
			rx_bit_tick_o <= 1'b0;
			rx_period_o <= `USTM_OS_NOMINAL;
		end else begin
			rx_bit_tick_o <= 1'b0;
			if (os_tick_i) begin
				rx_prev_r <= rx_line_i;
				if (ph_end) begin
					ph_r <= 5'h00;
					per_r <= over8_i ? `USTM_OS_EIGHT : `USTM_OS_NOMINAL;
					adj_done_r <= 1'b0;
					rx_bit_tick_o <= 1'b1;
					rx_period_o <= per_r;
				end else begin
					ph_r <= ph_r + 5'h01;
				end
				if (rx_edge && drift_on && !adj_done_r && !ph_end) begin
					// Within one clock of the boundary is jitter and left alone
					if ((early >= `USTM_EARLY_NEAR) && (early <= `USTM_EARLY_FAR)) begin
						per_r <= `USTM_OS_SHORT;
						adj_done_r <= 1'b1;
					end else if ((ph_r >= `USTM_LATE_NEAR) && (ph_r <= `USTM_LATE_FAR)) begin
						per_r <= `USTM_OS_LONG;
						adj_done_r <= 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/ustm_rx_model.sv ====
// Far-end receiver model recording the line once per half bit
`timescale 1ns/10ps
`default_nettype none
module ustm_rx_model (
	// Clock
	input wire logic sys_clk_i,
	// Line and half-bit strobe
	input wire logic half_bit_tick_i,
	input wire logic txd_i,
	// Recorded halves, newest in bit 0
	output logic [63:0] hist_o
);
	always @(posedge sys_clk_i) begin
		if (half_bit_tick_i) begin
			hist_o <= {hist_o[62:0], txd_i};
		end
	end
endmodule
`default_nettype wire

// ==== verif/ustm_tx_checker.sv ====
// Port assertions for the serial transmitter
`timescale 1ns/10ps
`default_nettype none
module ustm_tx_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Inputs watched
	input wire logic tx_enable_cmd_i,
	input wire logic tx_holding_wr_i,
	input wire logic half_bit_tick_i,
	input wire logic drift_enable_i,
	input wire logic over8_i,
	// Outputs watched
	input wire logic tx_holding_free_o,
	input wire logic tx_all_done_o,
	input wire logic tx_enabled_o,
	input wire logic txd_o,
	input wire logic rx_bit_tick_o,
	input wire logic [4:0] rx_period_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wr_taken;
		tx_holding_wr_i && tx_holding_free_o;
	endsequence
	sequence s_off;
		!tx_enabled_o ##1 !tx_enabled_o;
	endsequence
	AST_OFF_FLAGS: assert property (s_off |-> !tx_holding_free_o && !tx_all_done_o)
		else $error("flag high while disabled");
	AST_WR_BUSY: assert property (s_wr_taken |=> !tx_all_done_o)
		else $error("done high after accepted write");
	AST_EN: assert property (tx_enable_cmd_i |-> ##2 tx_enabled_o)
		else $error("enable not taken");
	AST_EN_CAUSE: assert property ($rose(tx_enabled_o) |-> $past(tx_enable_cmd_i, 2))
		else $error("enabled without command");
	AST_IDLE_HIGH: assert property (tx_all_done_o |-> txd_o)
		else $error("line low while done");
	AST_LINE_TICK: assert property (!$stable(txd_o) |-> $past(half_bit_tick_i))
		else $error("line moved off strobe");
	AST_DRIFT_OFF: assert property (rx_bit_tick_o && !over8_i && !drift_enable_i
		&& !$past(drift_enable_i, 20) |-> rx_period_o == 5'h10)
		else $error("period adjusted while off");
	AST_PERIOD_SET: assert property (rx_bit_tick_o && !over8_i |-> rx_period_o inside {5'h0F, 5'h10, 5'h11})
		else $error("period out of range");
	AST_TICK_PULSE: assert property (rx_bit_tick_o && !over8_i |=> !rx_bit_tick_o [*8])
		else $error("bit periods too close");
endmodule
bind ustm_tx ustm_tx_checker ustm_tx_checker_i (.sys_clk_i, .rst_n_i, .tx_enable_cmd_i, .tx_holding_wr_i,
	.half_bit_tick_i, .drift_enable_i, .over8_i, .tx_holding_free_o, .tx_all_done_o, .tx_enabled_o, .txd_o,
	.rx_bit_tick_o, .rx_period_o);
`default_nettype wire

// ==== verif/ustm_tx_bench.sv ====
// Self-checking bench for the serial transmitter
`timescale 1ns/10ps
`default_nettype none
module ustm_tx_bench;
	logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, dis = 1'b0, nine = 1'b0, bit_order_select = 1'b0, smode = 1'b0, manchester_enable = 1'b0;
	logic pol = 1'b0, single_bit_delimiter = 1'b1, styp = 1'b0, vsync = 1'b0, wr = 1'b0, sb = 1'b0, tick = 1'b0;
	logic drift = 1'b0, ov8 = 1'b0, rxl = 1'b1, free, done, enabled, txd, rxt;
	logic [1:0] char_length_field = 2'h3, stp = 2'h0, pp = 2'h0;
	logic [2:0] par = 3'h4;
	logic [3:0] plen = 4'h0;
	logic [8:0] wd = 9'h000;
	logic [4:0] rxp;
	logic [63:0] hist, ex;
	int el, acc, errors = 0, samples_checked = 0;
	always #20 clk = ~clk;
	always #280 rxl = ~rxl;
	ustm_tx ustm_tx_i (.sys_clk_i(clk), .rst_n_i(rst_n), .tx_enable_cmd_i(en), .tx_disable_cmd_i(dis),
		.char_length_field_i(char_length_field), .nine_bit_i(nine), .parity_select_i(par), .bit_order_select_i(bit_order_select),
		.stop_bit_count_i(stp), .sync_mode_i(smode), .manchester_enable_i(manchester_enable), .preamble_length_i(plen),
		.preamble_pattern_sel_i(pp), .encode_polarity_i(pol), .single_bit_delimiter_i(single_bit_delimiter),
		.sync_type_select_i(styp), .var_sync_i(vsync), .tx_holding_wr_i(wr), .tx_holding_data_i(wd),
		.char_sync_type_bit_i(sb), .half_bit_tick_i(tick), .tx_holding_free_o(free), .tx_all_done_o(done),
		.tx_enabled_o(enabled), .txd_o(txd), .drift_enable_i(drift), .over8_i(ov8), .os_tick_i(1'b1),
		.rx_line_i(rxl), .rx_bit_tick_o(rxt), .rx_period_o(rxp));
	ustm_rx_model ustm_rx_model_i (.sys_clk_i(clk), .half_bit_tick_i(tick), .txd_i(txd), .hist_o(hist));
	task conclude;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task put(input logic b);
		ex = {ex[62:0], b};
		el++;
	endtask
	task bit2(input logic b);
		put(manchester_enable ? b ^ pol : b);
		put(manchester_enable ? ~(b ^ pol) : b);
	endtask
	task build(input logic [8:0] d);
		int n;
		logic [8:0] m;
		ex = 64'h0;
		el = 0;
		n = nine ? 9 : 5 + char_length_field;
		m = d & ((9'h001 << n) - 9'h001);
		for (int i = 0; i < plen && manchester_enable; i++) bit2(pp[1] ? pp[0] ^ ~i[0] : ~pp[0]);
		if (!manchester_enable || single_bit_delimiter)
			bit2(1'b0);
		else begin
			repeat (3) put(vsync ? sb : styp);
			repeat (3) put(vsync ? ~sb : ~styp);
		end
		for (int i = 0; i < n; i++) bit2(bit_order_select ? d[n - 1 - i] : d[i]);
		if (par < 3'h4)
			bit2(par[1] ? par[0] : par[0] ^ (^m));
		repeat ((stp == 2'h0 || (stp == 2'h1 && smode)) ? 2 : (stp == 2'h1 ? 3 : 4)) put(1'b1);
	endtask
	task wr_char(input logic [8:0] d, input logic b);
		@(negedge clk);
		wr = 1'b1;
		wd = d;
		sb = b;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task ticks(input int k);
		repeat (k) begin
			@(negedge clk);
			tick = 1'b1;
			@(negedge clk);
			tick = 1'b0;
			repeat (2) @(negedge clk);
		end
	endtask
	task send(input logic [8:0] d, input logic b);
		wr_char(d, b);
		build(d);
		ticks(el + 1);
		chk(hist & ((64'h1 << el) - 64'h1), ex);
		chk({free, done}, 2'h3);
	endtask
	initial begin
		#2000000;
		errors++;
		conclude;
	end
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		chk({enabled, free, done}, 3'h0);
		wr_char(9'h055, 1'b0);
		chk({free, done}, 2'h0);
		en = 1'b1;
		@(negedge clk);
		en = 1'b0;
		repeat (3) @(negedge clk);
		chk({enabled, free, done}, 3'h7);
		while (rxt !== 1'b1) @(negedge clk);
		chk(rxp, 5'h10);
		for (int p = 0; p < 5; p++) begin
			par = p[2:0];
			send(9'h0B1 + p[8:0], 1'b0);
		end
		bit_order_select = 1'b1;
		stp = 2'h2;
		send(9'h0C5, 1'b0);
		stp = 2'h1;
		send(9'h036, 1'b0);
		smode = 1'b1;
		send(9'h036, 1'b0);
		nine = 1'b1;
		send(9'h1A3, 1'b0);
		nine = 1'b0;
		char_length_field = 2'h0;
		send(9'h1F3, 1'b0);
		$display("test frame formats done");
		{manchester_enable, plen, char_length_field, bit_order_select, stp, smode} = {1'b1, 4'h3, 2'h3, 4'h0};
		for (int k = 0; k < 8; k++) begin
			{pol, pp} = k[2:0];
			send(9'h0B1, 1'b0);
		end
		plen = 4'h0;
		send(9'h0B1, 1'b0);
		{single_bit_delimiter, drift} = 2'h1;
		for (int k = 0; k < 4; k++) begin
			{vsync, styp} = k[1:0];
			send(9'h03C, ~k[0]);
		end
		$display("test manchester done");
		{manchester_enable, single_bit_delimiter, par} = {2'h1, 3'h4};
		acc = 0;
		while (free === 1'b1 && acc < 5) begin
			wr_char(9'h0A0 + acc[8:0], 1'b0);
			acc++;
		end
		chk(acc, 3);
		wr_char(9'h0FF, 1'b0);
		build(9'h0A2);
		ticks(21);
		chk(free, 1'b1);
		ticks(39);
		chk(done, 1'b0);
		ticks(1);
		chk(hist & 64'hFFFFF, ex);
		chk(done, 1'b1);
		$display("test buffer done");
		dis = 1'b1;
		@(negedge clk);
		dis = 1'b0;
		repeat (3) @(negedge clk);
		chk({enabled, free, done}, 3'h0);
		$display("test disable done");
		ov8 = 1'b1;
		repeat (2) begin
			@(negedge clk);
			while (rxt !== 1'b1) @(negedge clk);
		end
		chk(rxp, 5'h08);
		$display("test oversampling done");
		conclude;
	end
endmodule
`default_nettype wire
